// [rtl/supply_supervisor.v]
// undervoltage reset and undervoltage detector logic with register port
`include "supply_supervisor_map.vh"
`default_nettype none
module supply_supervisor #(
	parameter QUAL_CNT = `QUAL_CYCLES
) (
	input wire clk,
	input wire rst_n,
	input wire clk_en,
	input wire [3:0] addr,
	input wire [7:0] wdata,
	input wire wr,
	input wire rd,
	output reg [7:0] rdata,
	// comparator outputs, one per reset option and per detect level, high when supply low, release outputs high when supply above
	input wire [2:0] below_reset_level,
	input wire [2:0] above_release_level,
	input wire [3:0] below_detect_level,
	input wire converter_event,
	input wire global_irq_on_instr,
	input wire global_irq_off_instr,
	input wire sleep_instr,
	input wire fetch,
	output reg sys_reset,
	output wire [1:0] detect_level_sel,
	output wire detect_enable_out,
	output wire irq_req,
	output wire [11:0] irq_vector,
	output wire vector_take,
	output reg wake,
	output reg asleep,
	output wire irq
);
	reg [7:0] ctl_r;
	reg [7:0] st_r;
	reg [7:0] io_irq_mask_reg_r;
	reg [1:0] opt_r;
	reg gie_r;
	reg [2:0] rs1_r, rs2_r;
	reg [2:0] rl1_r, rl2_r;
	reg [3:0] dt1_r, dt2_r;
	reg cv1_r, cv2_r, cv3_r;
	reg det_prev_r;
	reg [13:0] qual_r;
	wire [1:0] lvl;
	wire detect_low;
	wire det_rise;
	wire below_rst;
	wire above_rel;
	wire qual_done;

	// ==========================================
	// option decode
	function sel3;
		input [2:0] v;
		input [1:0] s;
		begin
			case (s)
				2'h2: sel3 = v[0];
				2'h1: sel3 = v[1];
				2'h0: sel3 = v[2];
				default: sel3 = 1'b0;
			endcase
		end
	endfunction

	// ==========================================
	// synchronisers
	// two stages before any logic looks at comparators
	// two-stage sync
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rs1_r <= 3'h0;
			rs2_r <= 3'h0;
			rl1_r <= 3'h0;
			rl2_r <= 3'h0;
			dt1_r <= 4'h0;
			dt2_r <= 4'h0;
			cv1_r <= 1'b0;
			cv2_r <= 1'b0;
			cv3_r <= 1'b0;
		end else if (clk_en) begin
			rs1_r <= below_reset_level;
			rs2_r <= rs1_r;
			rl1_r <= above_release_level;
			rl2_r <= rl1_r;
			dt1_r <= below_detect_level;
			dt2_r <= dt1_r;
			cv1_r <= converter_event;
			cv2_r <= cv1_r;
			cv3_r <= cv2_r;
		end
	end

	// ==========================================
	// undervoltage reset
	// level option decode
	assign below_rst = sel3(rs2_r, opt_r);
	assign above_rel = sel3(rl2_r, opt_r);
	assign qual_done = (qual_r >= QUAL_CNT[13:0]);
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			qual_r <= 14'h0;
			sys_reset <= 1'b0;
		end else if (clk_en) begin
			if (opt_r == `RST_OPT_NONE) begin
				qual_r <= 14'h0;
				sys_reset <= 1'b0;
			end else if (sys_reset) begin
				qual_r <= 14'h0;
				if (above_rel)
					sys_reset <= 1'b0;
			end else if (below_rst) begin
				if (qual_done)
					sys_reset <= 1'b1;
				else
					qual_r <= qual_r + 14'h1;
			end else begin
				qual_r <= 14'h0;
			end
		end
	end

	// ==========================================
	// detector
	// threshold select, 11 lowest
	assign lvl = ctl_r[`CTL_LVL_HI:`CTL_LVL_LO];
	assign detect_level_sel = lvl;
	assign detect_enable_out = ctl_r[`CTL_DET_EN];
	// detector gated by enable; runs in sleep only with wake enabled
	assign detect_low = ctl_r[`CTL_DET_EN] & dt2_r[lvl] &
		(~asleep | st_r[`ST_DET_WAKE]);
	assign det_rise = detect_low & ~det_prev_r;

	// ==========================================
	// registers
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctl_r <= `CTL_RESET;
			st_r <= `ST_RESET;
			io_irq_mask_reg_r <= `IRQ_MASK_RESET;
			opt_r <= `OPT_RESET;
			gie_r <= 1'b0;
			det_prev_r <= 1'b0;
			asleep <= 1'b0;
			wake <= 1'b0;
		end else if (clk_en) begin
			det_prev_r <= detect_low;
			wake <= 1'b0;
			if (sys_reset) begin
				st_r[`ST_DET_FLAG:`ST_SPARE_FLAG] <= 3'h0;
				gie_r <= 1'b0;
				asleep <= 1'b0;
			end else begin
				if (wr && addr == `ADDR_CONTROL)
					ctl_r <= wdata & `CTL_WR_MASK;
				if (wr && addr == `ADDR_IRQ_MASK)
					io_irq_mask_reg_r <= wdata;
				if (wr && addr == `ADDR_OPTION)
					opt_r <= wdata[1:0];
				if (wr && addr == `ADDR_STATUS) begin
					st_r[`ST_DET_WAKE] <= wdata[`ST_DET_WAKE];
					st_r[`ST_CHG_WAKE] <= wdata[`ST_CHG_WAKE];
					st_r[`ST_CONV_WAKE] <= wdata[`ST_CONV_WAKE];
				end
				// software can only clear, set wins
				st_r[`ST_DET_FLAG] <= det_rise | (st_r[`ST_DET_FLAG] &
					~(wr && addr == `ADDR_STATUS && !wdata[`ST_DET_FLAG]));
				st_r[`ST_CONV_FLAG] <= (cv2_r & ~cv3_r) | (st_r[`ST_CONV_FLAG] &
					~(wr && addr == `ADDR_STATUS && !wdata[`ST_CONV_FLAG]));
				st_r[`ST_SPARE_FLAG] <= st_r[`ST_SPARE_FLAG] &
					~(wr && addr == `ADDR_STATUS && !wdata[`ST_SPARE_FLAG]);
				if (global_irq_on_instr)
					gie_r <= 1'b1;
				else if (global_irq_off_instr || vector_take)
					gie_r <= 1'b0;
				if (sleep_instr)
					asleep <= 1'b1;
				else if (asleep && det_rise && st_r[`ST_DET_WAKE]) begin
					asleep <= 1'b0;
					wake <= 1'b1;
				end
			end
		end
	end

	// ==========================================
	// interrupt request and vector
	// interrupt enable gates request
	assign irq_req = st_r[`ST_DET_FLAG] & ctl_r[`CTL_IRQ_EN];
	assign vector_take = irq_req & gie_r & fetch & ~sys_reset;
	assign irq_vector = `DET_VECTOR;
	assign irq = irq_req | (st_r[`ST_CONV_FLAG] & io_irq_mask_reg_r[`ST_CONV_FLAG]);

	// ==========================================
	// read port, data one cycle after strobe
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= 8'h00;
		end else if (clk_en) begin
			rdata <= 8'h00;
			if (rd) begin
				case (addr)
					`ADDR_CONTROL: rdata <= ctl_r;
					`ADDR_STATUS: rdata <= {~detect_low,
						st_r[`ST_DET_FLAG] & ctl_r[`CTL_IRQ_EN],
						st_r[`ST_CONV_FLAG] & io_irq_mask_reg_r[`ST_CONV_FLAG],
						st_r[`ST_SPARE_FLAG] & io_irq_mask_reg_r[`ST_SPARE_FLAG],
						st_r[3:0]};
					`ADDR_IRQ_MASK: rdata <= io_irq_mask_reg_r;
					`ADDR_OPTION: rdata <= {6'h00, opt_r};
					default: rdata <= 8'h00;
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// [rtl/supply_supervisor_map.vh]
// register offsets, field positions and timing counts of the supply supervisor
// Notes on behaviour
// - reset asserted after supply stays below reset level for qualifying time, until release
// - reset option 11 none, 10 2.7/2.9V, 01 3.5/3.7V, 00 4.0/4.2V
// - control bit 7 gates the detector interrupt request
// - control bit 6 enables the detector; readable and writable
// - level field bits 5..4 select detect threshold; detect when at or below
// - status bit 7 is read-only active-low detect state
// - detect state reads 1 while detector disabled
// - status bits 6..4 cleared by software write, never set by it
// - status read returns flags anded with their mask bits
// - wake enable bit 0 keeps detector working in sleep and wakes device
// - falling across threshold sets flag, clears state, wakes if enabled
// - above threshold flag stays 0 and state stays 1
// - any system reset clears the detector flag
// - enabled and set flag branches next fetch to vector 021H
// - enable and disable instructions set and clear global interrupt enable
`ifndef SUPPLY_SUPERVISOR_MAP_VH
`define SUPPLY_SUPERVISOR_MAP_VH
// ==========================================
// register offsets
`define ADDR_CONTROL 4'h0
`define ADDR_STATUS 4'h1
`define ADDR_IRQ_MASK 4'h2
`define ADDR_OPTION 4'h3
// ==========================================
// field positions
`define CTL_IRQ_EN 7
`define CTL_DET_EN 6
`define CTL_LVL_HI 5
`define CTL_LVL_LO 4
`define CTL_EXT_WAKE 0
`define ST_STATE_N 7
`define ST_DET_FLAG 6
`define ST_CONV_FLAG 5
`define ST_SPARE_FLAG 4
`define ST_CONV_WAKE 3
`define ST_CHG_WAKE 1
`define ST_DET_WAKE 0
`define CTL_WR_MASK 8'hF1
`define ST_WR_MASK 8'h0B
`define ST_CLR_MASK 8'h70
// ==========================================
// reset values and codes
`define CTL_RESET 8'h00
`define ST_RESET 8'h00
`define IRQ_MASK_RESET 8'hFF
`define OPT_RESET 2'h3
`define RST_OPT_NONE 2'h3
`define DET_VECTOR 12'h021
// ==========================================
// timing
`define QUAL_TIME_NS 10000
`define CLK_PERIOD_NS 100
`define QUAL_CYCLES ((`QUAL_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// [test/supply_supervisor_monitor.sv]
// assertion checker on the supply supervisor ports
`default_nettype none
module supply_supervisor_monitor #(parameter int QUAL_CNT = 100) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic [3:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [7:0] rdata,
	input wire logic [2:0] below_reset_level,
	input wire logic global_irq_on_instr,
	input wire logic global_irq_off_instr,
	input wire logic fetch,
	input wire logic sys_reset,
	input wire logic [1:0] detect_level_sel,
	input wire logic detect_enable_out,
	input wire logic irq_req,
	input wire logic [11:0] irq_vector,
	input wire logic vector_take,
	input wire logic wake,
	input wire logic asleep
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	// ==========================================
	// properties
	AST_VECTOR: assert property (vector_take |-> irq_req && fetch && irq_vector == 12'h021)
		else $error("vector without request");
	AST_GIE_OFF: assert property (global_irq_off_instr && !global_irq_on_instr |=> !vector_take)
		else $error("vector after disable");
	AST_MASK: assert property (wr && clk_en && !sys_reset && addr == 4'h0 && !wdata[7] |=> !irq_req)
		else $error("masked request seen");
	AST_CTL: assert property (wr && clk_en && !sys_reset && addr == 4'h0 |=>
		detect_enable_out == $past(wdata[6]) && detect_level_sel == $past(wdata[5:4]))
		else $error("control not applied");
	AST_STATE: assert property (rd && clk_en && addr == 4'h1 && !detect_enable_out |=> rdata[7])
		else $error("state low while disabled");
	AST_RDATA: assert property (rdata != 8'h00 |-> $past(rd))
		else $error("read data without read");
	AST_WAKE: assert property (wake |-> $past(asleep) ##1 !wake)
		else $error("bad wake pulse");
	AST_RST_CAUSE: assert property ($rose(sys_reset) |-> $past(|below_reset_level, 3))
		else $error("reset without low supply");
endmodule
bind supply_supervisor supply_supervisor_monitor #(.QUAL_CNT(QUAL_CNT)) mon (.clk, .rst_n,
	.clk_en, .addr, .wdata, .wr, .rd, .rdata, .below_reset_level, .global_irq_on_instr,
	.global_irq_off_instr, .fetch, .sys_reset, .detect_level_sel, .detect_enable_out,
	.irq_req, .irq_vector, .vector_take, .wake, .asleep);
`default_nettype wire

// [test/supply_supervisor_tb.sv]
// self-checking bench for the supply supervisor
`default_nettype none
module supply_supervisor_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int QUAL = 4;
	logic clk = 0, rst_n = 0, wr = 0, rd = 0, gon = 0, goff = 0, slp = 0;
	logic [3:0] addr = 0, bdl = 0;
	logic [7:0] wdata = 0, rdata, v, c;
	logic [2:0] brl = 0, arl = 0;
	logic sys_reset, vector_take, wake, asleep, irq_req, irq;
	int num_errors = 0, compares = 0, seed = 51, lvl, takes = 0;
	supply_supervisor #(.QUAL_CNT(QUAL)) DUT (.clk(clk), .rst_n(rst_n), .clk_en(1'b1),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .below_reset_level(brl),
		.above_release_level(arl), .below_detect_level(bdl), .converter_event(1'b0),
		.global_irq_on_instr(gon), .global_irq_off_instr(goff), .sleep_instr(slp),
		.fetch(1'b1), .sys_reset(sys_reset), .detect_level_sel(), .detect_enable_out(),
		.irq_req(irq_req), .irq_vector(), .vector_take(vector_take), .wake(wake),
		.asleep(asleep), .irq(irq));
	initial forever #50 clk = ~clk;
	always @(posedge clk) if (vector_take === 1'b1) takes++;
	// ==========================================
	// tasks
	task automatic chk(input logic [7:0] s, e);
		compares++;
		if (s !== e) begin
			num_errors++;
			$display("ERROR %0t %h %h", $time, s, e);
		end
	endtask
	task automatic wreg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= 1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 0;
	endtask
	task automatic rreg(input logic [3:0] a);
		@(posedge clk);
		rd <= 1;
		addr <= a;
		@(posedge clk);
		rd <= 0;
		#1 v = rdata;
	endtask
	function automatic logic [7:0] exp_reset(input int a);
		case (a)
			1: return 8'h80;
			2: return 8'hFF;
			3: return 8'h03;
			default: return 8'h00;
		endcase
	endfunction
	task automatic tally_and_finish;
		if (num_errors == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// ==========================================
	// sequence
	initial begin
		repeat (3) @(posedge clk);
		rst_n <= 1;
		for (int a = 0; a < 5; a++) begin
			rreg(a[3:0]);
			chk(v, exp_reset(a));
		end
		wreg(4'hF, 8'($random(seed)));
		rreg(4'hF);
		chk(v, 8'h00);
		// global enable first, then level, interrupt enable and detector enable in one control write
		@(posedge clk);
		goff <= 1;
		@(posedge clk);
		goff <= 0;
		gon <= 1;
		@(posedge clk);
		gon <= 0;
		for (lvl = 0; lvl < 4; lvl++) begin
			c = {2'b11, lvl[1:0], 4'h0};
			wreg(4'h1, 8'h00);
			wreg(4'h0, c);
			rreg(4'h0);
			chk(v, c);
			// other levels only, selected one stays low
			bdl <= 4'($random(seed)) & ~(4'h1 << lvl);
			repeat (6) @(posedge clk);
			rreg(4'h1);
			chk(v, 8'h80);
			bdl <= 4'h1 << lvl;
			repeat (6) @(posedge clk);
			chk(irq_req, 8'h01);
			chk(irq, 8'h01);
			rreg(4'h1);
			chk(v, 8'h40);
			bdl <= 4'h0;
			repeat (6) @(posedge clk);
			rreg(4'h1);
			chk(v, 8'hC0);
			wreg(4'h1, 8'hFF);
			rreg(4'h1);
			chk(v, 8'hCB);
			wreg(4'h1, 8'h00);
			rreg(4'h1);
			chk(v, 8'h80);
		end
		chk(8'(takes), 8'h01);
		wreg(4'h0, 8'hC0);
		wreg(4'h1, 8'h01);
		@(posedge clk);
		slp <= 1;
		@(posedge clk);
		slp <= 0;
		repeat (2) @(posedge clk);
		chk(asleep, 8'h01);
		bdl <= 4'h1;
		repeat (8) @(posedge clk);
		chk(asleep, 8'h00);
		wreg(4'h0, 8'h00);
		rreg(4'h1);
		chk(v & 8'h80, 8'h80);
		wreg(4'h3, 8'h02);
		brl <= 3'b001;
		repeat (QUAL + 8) @(posedge clk);
		chk(sys_reset, 8'h01);
		brl <= 3'b000;
		arl <= 3'b001;
		repeat (6) @(posedge clk);
		chk(sys_reset, 8'h00);
		wreg(4'h0, 8'h80);
		rreg(4'h1);
		chk(v & 8'h40, 8'h00);
		tally_and_finish();
	end
	// hang guard, many times the expected run
	initial begin
		#400000;
		num_errors++;
		tally_and_finish();
	end
endmodule
`default_nettype wire
